/* File: tcpe_encoder.sv */
// Time code pulse encoder: one pulse-width coded mark per second on a digital line.
// Assumes sec_tick is a one-cycle pulse from a timebase on the same clock.
//
// Notes on behaviour
// - A mark every second of the minute except second 59.
// - Missing mark at 59 tells the receiver the next mark starts a minute.
// - Mark leading edge follows the second tick of the timebase.
// - Zero bit is a 100 ms mark, one bit a 200 ms mark.
// - Time fields are sent as BCD, one bit per second.
// - Groups: minutes, hours, date, each followed by its own parity bit.
// - Each parity bit makes the group's count of ones even.
// - Second 17 is a one while summer time is in effect.
// - Second 16 is a one in the hour before a time changeover.
// - Second 19 announces a pending leap second.
// - Standard zone time is UTC plus one hour, plus two in summer.
// - Any other time base may be sent with the same coding.
// - Output is a plain 1 Hz logic level, no carrier.
// - Telegram is suppressed when time is implausible or not radio synced.
// - Fault replaces marks by a 2 Hz square or a silent line.
// - Second 15 is a one while the standby transmitter is the source.
//
// The register offsets and register access over APB were decided locally.
`default_nettype none

module tcpe_encoder
    import tcpe_pkg::*;
#(
    parameter int P_ZERO_CYC = ZERO_CYC,
    parameter int P_ONE_CYC = ONE_CYC,
    parameter int P_FAULT_CYC = FAULT_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sec_tick,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic pulse_out,
    output logic minute_strobe
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    // Address decode, used by both the read and the write paths
    function automatic logic tc_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction : tc_hit

    // Assemble the 59-bit telegram from staged time and flags
    function automatic logic [TEL_W-1:0] tc_build(input tcpe_time_s t, input tcpe_ctrl_s c);
        logic [TEL_W-1:0] v;
        v = '0;
        v[BIT_START] = 1'b0;
        v[BIT_STANDBY] = c.standby;
        v[BIT_ANNOUNCE] = c.announce;
        v[BIT_SUMMER] = c.summer;
        v[BIT_WINTER] = ~c.summer;
        v[BIT_LEAP] = c.leap;
        v[BIT_TIME_START] = 1'b1;
        v[MIN_LSB +: MIN_W] = t.minute;
        v[MIN_PAR] = ^t.minute;
        v[HR_LSB +: HR_W] = t.hour;
        v[HR_PAR] = ^t.hour;
        v[DATE_LSB +: DATE_W] = {t.year, t.month, t.dow, t.day};
        v[DATE_PAR] = ^{t.year, t.month, t.dow, t.day};
        return v;
    endfunction : tc_build

    // ----------------------------------------------------------------
    // Registers and state
    // ----------------------------------------------------------------
    tcpe_ctrl_s ctrl_reg;
    tcpe_time_s time_reg;
    logic [5:0] sec_reg;
    logic [5:0] sec_next;
    logic [TEL_W-1:0] tel_reg;
    tcpe_mode_e mode_reg;
    tcpe_mode_e mode_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] width_reg;
    logic pulse_reg;
    logic pulse_next;
    logic strobe_reg;
    logic [31:0] rdata_reg;
    logic err_reg;
    logic wr_en;
    logic fault;

    localparam logic [CNT_W-1:0] W_ZERO = CNT_W'(P_ZERO_CYC);
    localparam logic [CNT_W-1:0] W_ONE = CNT_W'(P_ONE_CYC);
    localparam logic [CNT_W-1:0] W_Q = CNT_W'(P_FAULT_CYC);
    localparam logic [CNT_W-1:0] W_SAT = CNT_W'(3 * P_FAULT_CYC);

    assign wr_en = psel && penable && pwrite;
    assign fault = !(ctrl_reg.time_ok && ctrl_reg.radio_sync);
    assign sec_next = (sec_reg == SEC_LAST) ? SEC_FIRST : sec_reg + 6'h01;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // No wait states; read data is latched in the setup cycle
    assign pready = 1'b1;
    assign prdata = rdata_reg;
    assign pslverr = err_reg;

    // Control and staged time, written by software
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= tcpe_ctrl_s'(CTRL_RESET);
            time_reg <= '0;
        end else if (wr_en) begin
            if (tc_hit(paddr, OFS_CTRL)) begin
                ctrl_reg <= tcpe_ctrl_s'(pwdata[7:0]);
            end
            // Software stages local time of the chosen zone with its offset applied
            if (tc_hit(paddr, OFS_TIME)) begin
                time_reg.minute <= pwdata[F_MIN_LSB +: MIN_W];
                time_reg.hour <= pwdata[F_HR_LSB +: HR_W];
            end
            if (tc_hit(paddr, OFS_DATE)) begin
                time_reg.day <= pwdata[F_DAY_LSB +: 6];
                time_reg.dow <= pwdata[F_DOW_LSB +: 3];
                time_reg.month <= pwdata[F_MON_LSB +: 5];
                time_reg.year <= pwdata[F_YEAR_LSB +: 8];
            end
        end
    end

    // Read mux and error answer, captured in the setup cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= '0;
            err_reg <= 1'b0;
        end else if (psel && !penable) begin
            rdata_reg <= '0;
            err_reg <= 1'b0;
            if (tc_hit(paddr, OFS_CTRL)) begin
                rdata_reg <= {24'h000000, ctrl_reg};
            end else if (tc_hit(paddr, OFS_TIME)) begin
                rdata_reg <= {18'h00000, time_reg.hour, 1'b0, time_reg.minute};
            end else if (tc_hit(paddr, OFS_DATE)) begin
                rdata_reg <= {time_reg.year, 3'h0, time_reg.month,
                              5'h00, time_reg.dow, 2'h0, time_reg.day};
            end else if (tc_hit(paddr, OFS_SECOND)) begin
                rdata_reg <= {26'h0000000, sec_reg};
            end else if (tc_hit(paddr, OFS_STATUS)) begin
                rdata_reg <= {18'h00000, sec_reg, 4'h0, mode_reg, fault, pulse_reg};
            end else begin
                err_reg <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Second position within the minute
    // ----------------------------------------------------------------
    // A write aligns the minute; it wins over a tick in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sec_reg <= SEC_LAST;
        end else if (wr_en && tc_hit(paddr, OFS_SECOND)) begin
            sec_reg <= pwdata[5:0];
        end else if (sec_tick) begin
            sec_reg <= sec_next;
        end
    end

    // Telegram latched at the minute mark; staged time describes that new minute
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tel_reg <= '0;
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= sec_tick && (sec_next == SEC_FIRST);
            if (sec_tick && (sec_next == SEC_FIRST)) begin
                tel_reg <= tc_build(time_reg, ctrl_reg);
            end
        end
    end
    assign minute_strobe = strobe_reg;

    // ----------------------------------------------------------------
    // Output mode, chosen once per second
    // ----------------------------------------------------------------
    always_comb begin
        case ({ctrl_reg.enable, fault})
            2'b10: mode_next = TC_CODE;
            2'b11: mode_next = ctrl_reg.fault_silent ? TC_SILENT : TC_FAULT_SQ;
            default: mode_next = TC_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg <= TC_OFF;
        end else if (sec_tick) begin
            mode_reg <= mode_next;
        end
    end

    // ----------------------------------------------------------------
    // Mark generator
    // ----------------------------------------------------------------
    // One counter times both marks and the fault square; it saturates so a
    // stopped timebase leaves the line idle instead of wrapping into a pulse
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= W_SAT;
            width_reg <= W_ZERO;
        end else if (sec_tick) begin
            cnt_reg <= CNT_W'(1);
            // Second 59 has no telegram bit; a zero width keeps the line low
            // instead of indexing past the end of the telegram
            if (sec_next == SEC_LAST) begin
                width_reg <= '0;
            end else if (sec_next != SEC_FIRST && sec_next < SEC_LAST && tel_reg[sec_next]) begin
                width_reg <= W_ONE;
            end else begin
                width_reg <= W_ZERO;
            end
        end else if (cnt_reg < W_SAT) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    always_comb begin
        case (mode_reg)
            TC_CODE: pulse_next = cnt_reg < width_reg;
            TC_FAULT_SQ: pulse_next = (cnt_reg < W_Q) ||
                                      (cnt_reg >= 2 * W_Q && cnt_reg < W_SAT);
            default: pulse_next = 1'b0;
        endcase
    end

    // Rising edge taken at the tick edge itself, so the onset carries the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pulse_reg <= 1'b0;
        end else if (sec_tick) begin
            case (mode_next)
                TC_CODE: pulse_reg <= (sec_next != SEC_LAST);
                TC_FAULT_SQ: pulse_reg <= 1'b1;
                default: pulse_reg <= 1'b0;
            endcase
        end else begin
            pulse_reg <= pulse_next;
        end
    end
    assign pulse_out = pulse_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_code_tick;
        sec_tick && mode_next == TC_CODE;
    endsequence

    sequence s_minute_load;
        sec_tick && sec_next == SEC_FIRST && !(wr_en && tc_hit(paddr, OFS_SECOND));
    endsequence

    a_gap_at_last: assert property (
        s_code_tick and (sec_next == SEC_LAST) |=> !pulse_out [*2])
        else $error("mark emitted in the last second");

    a_mark_onset: assert property (
        s_code_tick and (sec_next != SEC_LAST) |=> pulse_out && cnt_reg == CNT_W'(1))
        else $error("mark did not start at the second tick");

    a_mark_width: assert property (
        $fell(pulse_out) && mode_reg == TC_CODE && !$past(sec_tick)
        |-> cnt_reg == width_reg + CNT_W'(1))
        else $error("mark width differs from coded bit");

    a_width_pick: assert property (
        s_code_tick and (sec_next != SEC_FIRST) |=>
        width_reg == (($past(sec_next) == SEC_LAST) ? CNT_W'(0) :
                      ($past(sec_next) < SEC_LAST && $past(tel_reg[sec_next])) ? W_ONE : W_ZERO))
        else $error("mark width not taken from telegram bit");

    a_parity_even: assert property (
        ^tel_reg[MIN_PAR:MIN_LSB] == 1'b0 && ^tel_reg[HR_PAR:HR_LSB] == 1'b0 &&
        ^tel_reg[DATE_PAR:DATE_LSB] == 1'b0)
        else $error("group parity is odd");

    a_fixed_bits: assert property (
        s_minute_load |=> tel_reg[BIT_TIME_START] && !tel_reg[BIT_START] &&
        tel_reg[BIT_WINTER] == !tel_reg[BIT_SUMMER])
        else $error("fixed telegram bits wrong");

    a_flag_bits: assert property (
        s_minute_load |=> tel_reg[BIT_SUMMER] == $past(ctrl_reg.summer) &&
        tel_reg[BIT_STANDBY] == $past(ctrl_reg.standby) &&
        tel_reg[BIT_ANNOUNCE] == $past(ctrl_reg.announce) &&
        tel_reg[BIT_LEAP] == $past(ctrl_reg.leap))
        else $error("flag bits not latched at minute mark");

    a_fault_mode: assert property (
        sec_tick && ctrl_reg.enable && fault |=> mode_reg != TC_CODE)
        else $error("telegram sent while in fault");

    a_silent_line: assert property (
        mode_reg == TC_SILENT && !sec_tick |=> !pulse_out)
        else $error("silent fault mode drives the line");

    a_square_low: assert property (
        mode_reg == TC_FAULT_SQ && !sec_tick && cnt_reg == W_Q |=> !pulse_out)
        else $error("fault square not low in its second quarter");

endmodule : tcpe_encoder

`default_nettype wire

/* File: tcpe_pkg.sv */
// Package for the one-second pulse-width time code encoder.
// Assumes a 50 MHz system clock and an APB register port with 32-bit data.
`default_nettype none

package tcpe_pkg;
    // ----------------------------------------------------------------
    // Clock and mark timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int ZERO_MS = 100;
    localparam int ONE_MS = 200;
    localparam int FAULT_HALF_MS = 250;
    localparam int MS_DIV = 1000;
    localparam int ZERO_CYC = ZERO_MS * (CLK_HZ / MS_DIV);
    localparam int ONE_CYC = ONE_MS * (CLK_HZ / MS_DIV);
    localparam int FAULT_CYC = FAULT_HALF_MS * (CLK_HZ / MS_DIV);
    localparam int CNT_W = 28;

    // ----------------------------------------------------------------
    // Register map, byte addresses
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TIME = 8'h04;
    localparam logic [7:0] OFS_DATE = 8'h08;
    localparam logic [7:0] OFS_SECOND = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Telegram layout
    // ----------------------------------------------------------------
    localparam int TEL_W = 59;
    localparam logic [5:0] SEC_LAST = 6'h3B;
    localparam logic [5:0] SEC_FIRST = 6'h00;
    localparam int BIT_START = 0;
    localparam int BIT_STANDBY = 15;
    localparam int BIT_ANNOUNCE = 16;
    localparam int BIT_SUMMER = 17;
    localparam int BIT_WINTER = 18;
    localparam int BIT_LEAP = 19;
    localparam int BIT_TIME_START = 20;
    localparam int MIN_LSB = 21;
    localparam int MIN_W = 7;
    localparam int MIN_PAR = 28;
    localparam int HR_LSB = 29;
    localparam int HR_W = 6;
    localparam int HR_PAR = 35;
    localparam int DATE_LSB = 36;
    localparam int DATE_W = 22;
    localparam int DATE_PAR = 58;

    // Field positions inside the TIME, DATE and STATUS words
    localparam int F_MIN_LSB = 0;
    localparam int F_HR_LSB = 8;
    localparam int F_DAY_LSB = 0;
    localparam int F_DOW_LSB = 8;
    localparam int F_MON_LSB = 16;
    localparam int F_YEAR_LSB = 24;
    localparam int F_SEC_LSB = 8;

    typedef struct packed {
        logic radio_sync;
        logic time_ok;
        logic standby;
        logic leap;
        logic announce;
        logic summer;
        logic fault_silent;
        logic enable;
    } tcpe_ctrl_s;

    typedef struct packed {
        logic [7:0] year;
        logic [4:0] month;
        logic [2:0] dow;
        logic [5:0] day;
        logic [5:0] hour;
        logic [6:0] minute;
    } tcpe_time_s;

    typedef enum logic [1:0] {
        TC_OFF = 2'b00,
        TC_CODE = 2'b01,
        TC_FAULT_SQ = 2'b10,
        TC_SILENT = 2'b11
    } tcpe_mode_e;
endpackage : tcpe_pkg

`default_nettype wire

/* File: tcpe_rx_model.sv */
// Receiver model for the pulse coded time line: measures marks and decodes bits.
// Assumes it samples the line on the encoder's clock with shortened mark counts.
`default_nettype none

module tcpe_rx_model
    import tcpe_pkg::*;
#(
    parameter int P_ZERO_CYC = 10,
    parameter int P_ONE_CYC = 20,
    parameter int P_GAP_CYC = 60
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic line_in,
    output int rises,
    output int width,
    output int idx,
    output logic [TEL_W-1:0] word
);
    logic prev;
    int hi;
    int lo;

    // --------------------------------------------------------------
    // Mark timing and bit decode
    // --------------------------------------------------------------
    // Threshold halfway between the two widths tolerates small skew
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev <= 1'b0;
            hi <= 0;
            lo <= 0;
            rises <= 0;
            width <= 0;
            idx <= 0;
            word <= '0;
        end else begin
            prev <= line_in;
            if (line_in && !prev) begin
                rises <= rises + 1;
                hi <= 1;
                idx <= (lo > P_GAP_CYC) ? 0 : idx + 1;
            end else if (line_in) begin
                hi <= hi + 1;
            end
            lo <= line_in ? 0 : lo + 1;
            if (!line_in && prev) begin
                width <= hi;
                if (idx < TEL_W) word[idx] <= (hi > (P_ZERO_CYC + P_ONE_CYC) / 2);
            end
        end
    end
endmodule : tcpe_rx_model

`default_nettype wire

/* File: time_code_pulse_encoder_tb_top.sv */
// Self-checking bench for the time code encoder with a receiver model on its line.
// Assumes shortened mark counts and a second tick every PER clock cycles.
`default_nettype none

module time_code_pulse_encoder_tb_top
    import tcpe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ZC = 10;
    localparam int OC = 20;
    localparam int FC = 8;
    localparam int PER = 40;
    logic clk, rst_b, sec_tick, psel, penable, pwrite, pready, pslverr, pulse_out;
    logic minute_strobe, rerr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdata, t, d, c;
    logic [TEL_W-1:0] rx_word, exp_tel;
    int miscompares, samples_checked, rises, width, idx, strobes, s0;
    int nr[3] = '{2, 0, 0};
    logic [7:0] cv[3] = '{8'h81, 8'h43, 8'hC0};

    tcpe_encoder #(.P_ZERO_CYC(ZC), .P_ONE_CYC(OC), .P_FAULT_CYC(FC)) tcpe_encoder_inst (
        .clk(clk), .rst_b(rst_b), .sec_tick(sec_tick), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pulse_out(pulse_out), .minute_strobe(minute_strobe));
    tcpe_rx_model #(.P_ZERO_CYC(ZC), .P_ONE_CYC(OC), .P_GAP_CYC(60)) tcpe_rx_model_inst (
        .clk(clk), .rst_b(rst_b), .line_in(pulse_out), .rises(rises), .width(width),
        .idx(idx), .word(rx_word));

    // --------------------------------------------------------------
    // Clock, strobe counter and watchdog
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) if (minute_strobe === 1'b1) strobes++;
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        end_of_test;
    end

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // Zero wait states are not assumed; the loop waits for pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 50) begin
            miscompares++;
            end_of_test;
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One second: tick, onset check, then rise count and last width
    task automatic sec(input logic mark, input int w, input int n);
        int r0;
        r0 = rises;
        @(posedge clk) sec_tick <= 1'b1;
        @(posedge clk) sec_tick <= 1'b0;
        #1 chk("mark onset", 64'(mark), 64'(pulse_out));
        repeat (PER - 2) @(posedge clk);
        #1 chk("mark count", n, rises - r0);
        if (n > 0) chk("mark width", w, width);
    endtask : sec

    // Reference telegram built from the staged words
    function automatic logic [TEL_W-1:0] tel(input logic [31:0] tt, dd, cc);
        logic [TEL_W-1:0] b;
        b = '0;
        b[15] = cc[5];
        b[16] = cc[3];
        b[17] = cc[2];
        b[18] = !cc[2];
        b[19] = cc[4];
        b[20] = 1'b1;
        b[27:21] = tt[6:0];
        b[28] = ^tt[6:0];
        b[34:29] = tt[13:8];
        b[35] = ^tt[13:8];
        b[57:36] = {dd[31:24], dd[20:16], dd[10:8], dd[5:0]};
        b[58] = ^b[57:36];
        return b;
    endfunction : tel

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        {rst_b, sec_tick, psel, penable, pwrite, paddr, pwdata} = '0;
        miscompares = 0;
        samples_checked = 0;
        strobes = 0;
        void'($urandom(32'hE7BF));
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        apb(0, OFS_STATUS, 0);
        chk("status after reset", 32'h00003B02, rdata);
        apb(1, 8'h14, 32'hFFFFFFFF);
        chk("unmapped write error", 1, rerr);
        apb(0, 8'h14, 0);
        chk("unmapped read", 33'h100000000, {rerr, rdata});
        apb(0, OFS_CTRL, 0);
        chk("ctrl untouched", 0, rdata);
        $display("test registers done");
        // Random time and flags; any time base is accepted as staged
        for (int m = 0; m < 2; m++) begin
            t = $urandom & 32'h00003F7F;
            d = $urandom & 32'hFF1F073F;
            c = 32'h000000C1 | ($urandom & 32'h0000003C);
            apb(1, OFS_TIME, t);
            apb(1, OFS_DATE, d);
            apb(1, OFS_CTRL, c);
            apb(1, OFS_SECOND, 32'h0000003A);
            apb(0, OFS_SECOND, 0);
            chk("second reg", 32'h0000003A, rdata);
            exp_tel = tel(t, d, c);
            s0 = strobes;
            sec(1'b0, 0, 0);
            for (int s = 0; s < TEL_W; s++) sec(1'b1, exp_tel[s] ? OC : ZC, 1);
            chk("telegram", exp_tel, rx_word);
            chk("bit index", TEL_W - 1, idx);
            chk("minute strobes", 1, strobes - s0);
            apb(0, OFS_STATUS, 0);
            chk("code mode", 1, rdata[3:2]);
        end
        $display("test telegram done");
        for (int i = 0; i < 3; i++) begin
            apb(1, OFS_CTRL, {24'h0, cv[i]});
            repeat (2) sec(i == 0, FC, nr[i]);
            apb(0, OFS_STATUS, 0);
            chk("fault mode", (i == 0) ? 2 : (i == 1) ? 3 : 0, rdata[3:2]);
        end
        $display("test fault done");
        end_of_test;
    end
endmodule : time_code_pulse_encoder_tb_top

`default_nettype wire
